// ### design/bcc_calendar_clock.sv
// Contract
// - 16 locations: 13 data, 3 control
// - digits use low 4/3/2/1 bits
// - weekday 3 bits, Sunday 000..Saturday 110
// - D: round, irq flag, busy, hold bits
// - round zeroes seconds, minute +1 if over 29
// - irq flag reads status, write 0 clears latch
// - busy 1: counters unsafe
// - hold write 1 loads written values
// - E period: 1/64 s, second, minute, hour
// - latched mode holds output low until cleared
// - standard mode pulses low 7.8125 ms
// - E mask bit 1 disables output
// - F test bit picks fast or normal source
// - F hour format: 24 hour or 12 AM/PM
// - F stop bit halts the divider
// - F reset clears sub-second stages only
// - locations ordered seconds to control F
// - hours tens carries the PM indication
`timescale 1ns/100ps
`default_nettype none

module bcc_calendar_clock #(
    parameter int unsigned IRQ_PULSE_CYCLES = bcc_pkg::IRQ_PULSE_CYCLES,
    parameter int unsigned PRESCALE = bcc_pkg::PRESCALE_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // host location bus
    input wire bcc_pkg::bcc_bus_t bus_in,
    output logic [7:0] rdata_out,
    // interrupt line, active low
    output logic irq_n_out
);

    localparam int unsigned CW = $clog2(IRQ_PULSE_CYCLES + 1);
    localparam logic [CW-1:0] PULSE_LAST = CW'(IRQ_PULSE_CYCLES - 1);

    generate
        if (IRQ_PULSE_CYCLES < 1)
        begin : g_bad
            $error("pulse length must be positive");
        end
    endgenerate

    typedef struct packed {
        bcc_pkg::bcc_time_t now;
        logic [bcc_pkg::DATA_LOCATIONS-1:0][7:0] shadow;
        logic [3:0] ctrl_e;
        logic [3:0] ctrl_f;
        bcc_pkg::bcc_irq_t irq_st;
        logic [CW-1:0] pulse_cnt;
        logic busy;
        logic irq_n;
        logic [7:0] rdata;
    } bcc_state_t;

    bcc_state_t s;
    bcc_state_t next_s;
    logic base_tick;
    logic tick64;
    logic sec_tick;

    // ------------------------------------------------------------
    // timebase divider
    // ------------------------------------------------------------
    bcc_timebase #(
        .PRESCALE(PRESCALE),
        .CHAIN_W(bcc_pkg::CHAIN_BITS)
    ) u_timebase (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .stop_in(s.ctrl_f[bcc_pkg::F_STOP_BIT]),
        .clear_in(s.ctrl_f[bcc_pkg::F_RESET_BIT]),
        .base_tick_out(base_tick),
        .tick64_out(tick64),
        .sec_tick_out(sec_tick)
    );

    // ------------------------------------------------------------
    // last day of the month, two digits
    // ------------------------------------------------------------
    function automatic logic [5:0] last_day(input bcc_pkg::bcc_time_t t);
        logic leap;
        logic [5:0] r;
        leap = t.yr10[0] ? (t.yr1 == 4'h2 || t.yr1 == 4'h6)
                         : (t.yr1 == 4'h0 || t.yr1 == 4'h4 || t.yr1 == 4'h8);
        r = {2'h3, 4'h1};
        if (!t.mon10 && t.mon1 == 4'h2)
            r = leap ? {2'h2, 4'h9} : {2'h2, 4'h8};
        else if ((!t.mon10 && (t.mon1 == 4'h4 || t.mon1 == 4'h6
                  || t.mon1 == 4'h9)) || (t.mon10 && t.mon1 == 4'h1))
            r = {2'h3, 4'h0};
        return r;
    endfunction

    // ------------------------------------------------------------
    // bus decode, counting, interrupt and read path
    // ------------------------------------------------------------
    always_comb
    begin
        logic wr_d;
        logic load;
        logic round;
        logic irq_clr;
        logic count_tick;
        logic min_adv;
        logic hr_adv;
        logic day_adv;
        logic mon_adv;
        logic yr_adv;
        logic ev;
        logic h24;
        logic [7:0] rd;
        bcc_pkg::bcc_time_t t;
        wr_d = 1'b0;
        load = 1'b0;
        round = 1'b0;
        irq_clr = 1'b0;
        min_adv = 1'b0;
        hr_adv = 1'b0;
        day_adv = 1'b0;
        mon_adv = 1'b0;
        yr_adv = 1'b0;
        ev = 1'b0;
        rd = 8'h00;
        next_s = s;
        t = s.now;
        h24 = s.ctrl_f[bcc_pkg::F_24H_BIT];

        // host writes to data locations land in holding bytes
        if (bus_in.wr)
        begin
            if (bus_in.addr <= bcc_pkg::OFF_DOW_CODE)
                next_s.shadow[bus_in.addr] = bus_in.wdata;
            else if (bus_in.addr == bcc_pkg::OFF_CTRL_CMD_STATUS)
                wr_d = 1'b1;
            else if (bus_in.addr == bcc_pkg::OFF_CTRL_IRQ_SETUP)
                next_s.ctrl_e = bus_in.wdata[3:0];
            else
                next_s.ctrl_f = bus_in.wdata[3:0];
        end
        load = wr_d && bus_in.wdata[bcc_pkg::D_HOLD_BIT];
        round = wr_d && bus_in.wdata[bcc_pkg::D_ROUND_BIT];
        irq_clr = wr_d && !bus_in.wdata[bcc_pkg::D_IRQ_BIT];
        count_tick = s.ctrl_f[bcc_pkg::F_TEST_BIT] ? base_tick
                                                    : sec_tick;

        if (load)
        begin
            // copy holding bytes into counters
            t.seconds_ones = s.shadow[0][3:0];
            t.seconds_tens = s.shadow[1][2:0];
            t.minutes_ones = s.shadow[2][3:0];
            t.minutes_tens = s.shadow[3][2:0];
            t.hr1 = s.shadow[4][3:0];
            t.hr10 = s.shadow[5][1:0];
            t.pm = s.shadow[5][bcc_pkg::HR10_PM_BIT];
            t.day1 = s.shadow[6][3:0];
            t.day10 = s.shadow[7][1:0];
            t.mon1 = s.shadow[8][3:0];
            t.mon10 = s.shadow[9][0];
            t.yr1 = s.shadow[10][3:0];
            t.yr10 = s.shadow[11][1:0];
            t.dow = s.shadow[12][2:0];
        end
        else
        begin
            if (round)
            begin
                t.seconds_ones = 4'h0;
                t.seconds_tens = 3'h0;
                min_adv = s.now.seconds_tens >= 3'h3;
            end
            else if (count_tick)
            begin
                // seconds digits
                if (t.seconds_ones != 4'h9)
                    t.seconds_ones = t.seconds_ones + 4'h1;
                else
                begin
                    t.seconds_ones = 4'h0;
                    if (t.seconds_tens == 3'h5)
                    begin
                        t.seconds_tens = 3'h0;
                        min_adv = 1'b1;
                    end
                    else
                        t.seconds_tens = t.seconds_tens + 3'h1;
                end
            end
            if (min_adv)
            begin
                if (t.minutes_ones != 4'h9)
                    t.minutes_ones = t.minutes_ones + 4'h1;
                else
                begin
                    t.minutes_ones = 4'h0;
                    if (t.minutes_tens == 3'h5)
                    begin
                        t.minutes_tens = 3'h0;
                        hr_adv = 1'b1;
                    end
                    else
                        t.minutes_tens = t.minutes_tens + 3'h1;
                end
            end
            if (hr_adv)
            begin
                if (h24 && t.hr10 == 2'h2 && t.hr1 == 4'h3)
                begin
                    t.hr10 = 2'h0; // 23 rolls to 00
                    t.hr1 = 4'h0;
                    day_adv = 1'b1;
                end
                else if (!h24 && t.hr10 == 2'h1 && t.hr1 == 4'h2)
                begin
                    t.hr10 = 2'h0; // 12 rolls to 01
                    t.hr1 = 4'h1;
                end
                else if (!h24 && t.hr10 == 2'h1 && t.hr1 == 4'h1)
                begin
                    t.hr1 = 4'h2;
                    t.pm = !t.pm;
                    day_adv = s.now.pm;
                end
                else if (t.hr1 == 4'h9)
                begin
                    t.hr1 = 4'h0;
                    t.hr10 = t.hr10 + 2'h1;
                end
                else
                    t.hr1 = t.hr1 + 4'h1;
            end
            if (day_adv)
            begin
                t.dow = (t.dow == 3'h6) ? 3'h0 : t.dow + 3'h1;
                if ({t.day10, t.day1} == last_day(t))
                begin
                    t.day10 = 2'h0;
                    t.day1 = 4'h1;
                    mon_adv = 1'b1;
                end
                else if (t.day1 == 4'h9)
                begin
                    t.day1 = 4'h0;
                    t.day10 = t.day10 + 2'h1;
                end
                else
                    t.day1 = t.day1 + 4'h1;
            end
            if (mon_adv)
            begin
                if (t.mon10 && t.mon1 == 4'h2)
                begin
                    t.mon10 = 1'b0;
                    t.mon1 = 4'h1;
                    yr_adv = 1'b1;
                end
                else if (t.mon1 == 4'h9)
                begin
                    t.mon10 = 1'b1;
                    t.mon1 = 4'h0;
                end
                else
                    t.mon1 = t.mon1 + 4'h1;
            end
            if (yr_adv)
            begin
                if (t.yr1 != 4'h9)
                    t.yr1 = t.yr1 + 4'h1;
                else
                begin
                    t.yr1 = 4'h0;
                    t.yr10 = t.yr10 + 2'h1; // tens wrap in two bits
                end
            end
        end
        next_s.now = t;
        next_s.busy = load || round || count_tick;

        // periodic event selection
        case (bcc_pkg::bcc_period_t'(s.ctrl_e[bcc_pkg::E_PERIOD_LSB +: 2]))
            bcc_pkg::PER_64TH: ev = tick64;
            bcc_pkg::PER_SECOND: ev = count_tick && !load && !round;
            bcc_pkg::PER_MINUTE: ev = min_adv;
            bcc_pkg::PER_HOUR: ev = hr_adv;
            default: ev = 1'b0;
        endcase

        // interrupt waveform; a new event wins over a clear
        case (s.irq_st)
            bcc_pkg::IRQ_IDLE:
            begin
                if (ev && s.ctrl_e[bcc_pkg::E_WAVE_BIT])
                    next_s.irq_st = bcc_pkg::IRQ_LATCH;
                else if (ev)
                begin
                    next_s.irq_st = bcc_pkg::IRQ_PULSE;
                    next_s.pulse_cnt = PULSE_LAST;
                end
            end
            bcc_pkg::IRQ_PULSE:
            begin
                if (ev)
                    next_s.pulse_cnt = PULSE_LAST;
                else if (s.pulse_cnt == '0)
                    next_s.irq_st = bcc_pkg::IRQ_IDLE;
                else
                    next_s.pulse_cnt = s.pulse_cnt - 1'b1;
            end
            bcc_pkg::IRQ_LATCH:
            begin
                if (irq_clr && !ev)
                    next_s.irq_st = bcc_pkg::IRQ_IDLE;
            end
            default: next_s.irq_st = bcc_pkg::IRQ_IDLE;
        endcase
        next_s.irq_n = (next_s.irq_st == bcc_pkg::IRQ_IDLE)
                       || next_s.ctrl_e[bcc_pkg::E_MASK_BIT];

        // read path, upper bits zero
        case (bus_in.addr)
            bcc_pkg::OFF_SECONDS_ONES: rd = {4'h0, s.now.seconds_ones};
            bcc_pkg::OFF_SECONDS_TENS: rd = {5'h00, s.now.seconds_tens};
            bcc_pkg::OFF_MINUTES_ONES: rd = {4'h0, s.now.minutes_ones};
            bcc_pkg::OFF_MINUTES_TENS: rd = {5'h00, s.now.minutes_tens};
            bcc_pkg::OFF_HOURS_ONES: rd = {4'h0, s.now.hr1};
            bcc_pkg::OFF_HOURS_TENS: rd = {5'h00, s.now.pm, s.now.hr10};
            bcc_pkg::OFF_DAY_ONES: rd = {4'h0, s.now.day1};
            bcc_pkg::OFF_DAY_TENS: rd = {6'h00, s.now.day10};
            bcc_pkg::OFF_MONTH_ONES: rd = {4'h0, s.now.mon1};
            bcc_pkg::OFF_MONTH_TENS: rd = {7'h00, s.now.mon10};
            bcc_pkg::OFF_YEARS_ONES: rd = {4'h0, s.now.yr1};
            bcc_pkg::OFF_YEARS_TENS: rd = {6'h00, s.now.yr10};
            bcc_pkg::OFF_DOW_CODE: rd = {5'h00, s.now.dow};
            bcc_pkg::OFF_CTRL_CMD_STATUS:
                rd = {5'h00, s.irq_st != bcc_pkg::IRQ_IDLE,
                      s.busy, 1'b0};
            bcc_pkg::OFF_CTRL_IRQ_SETUP: rd = {4'h0, s.ctrl_e};
            bcc_pkg::OFF_CTRL_COUNT_SETUP: rd = {4'h0, s.ctrl_f};
            default: rd = 8'h00;
        endcase
        if (bus_in.rd)
            next_s.rdata = rd;
    end

    // state register with reset values
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            s <= '0;
            s.now.day1 <= bcc_pkg::RST_DAY_ONES;
            s.now.mon1 <= bcc_pkg::RST_MONTH_ONES;
            s.ctrl_e <= bcc_pkg::RST_CTRL_IRQ_SETUP;
            s.ctrl_f <= bcc_pkg::RST_CTRL_COUNT_SETUP;
            s.irq_st <= bcc_pkg::IRQ_IDLE;
            s.irq_n <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign rdata_out = s.rdata;
    assign irq_n_out = s.irq_n;

endmodule

`default_nettype wire

// ### design/bcc_pkg.sv
`default_nettype none

package bcc_pkg;

    // ----------------------------------------
    // clock and timebase
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned BASE_HZ = 32768;
    localparam int unsigned PRESCALE_CYCLES = CLK_HZ / BASE_HZ;
    localparam int unsigned CHAIN_BITS = 15;
    localparam int unsigned TICK64_BITS = 9;
    localparam int unsigned IRQ_PULSE_NS = 7_812_500;
    localparam int unsigned IRQ_PULSE_CYCLES = IRQ_PULSE_NS / CLK_PERIOD_NS;

    // ----------------------------------------
    // location offsets
    // ----------------------------------------
    localparam logic [3:0] OFF_SECONDS_ONES = 4'h0;
    localparam logic [3:0] OFF_SECONDS_TENS = 4'h1;
    localparam logic [3:0] OFF_MINUTES_ONES = 4'h2;
    localparam logic [3:0] OFF_MINUTES_TENS = 4'h3;
    localparam logic [3:0] OFF_HOURS_ONES = 4'h4;
    localparam logic [3:0] OFF_HOURS_TENS = 4'h5;
    localparam logic [3:0] OFF_DAY_ONES = 4'h6;
    localparam logic [3:0] OFF_DAY_TENS = 4'h7;
    localparam logic [3:0] OFF_MONTH_ONES = 4'h8;
    localparam logic [3:0] OFF_MONTH_TENS = 4'h9;
    localparam logic [3:0] OFF_YEARS_ONES = 4'hA;
    localparam logic [3:0] OFF_YEARS_TENS = 4'hB;
    localparam logic [3:0] OFF_DOW_CODE = 4'hC;
    localparam logic [3:0] OFF_CTRL_CMD_STATUS = 4'hD;
    localparam logic [3:0] OFF_CTRL_IRQ_SETUP = 4'hE;
    localparam logic [3:0] OFF_CTRL_COUNT_SETUP = 4'hF;
    localparam int unsigned DATA_LOCATIONS = 13;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int unsigned D_ROUND_BIT = 3;
    localparam int unsigned D_IRQ_BIT = 2;
    localparam int unsigned D_BUSY_BIT = 1;
    localparam int unsigned D_HOLD_BIT = 0;
    localparam int unsigned E_PERIOD_LSB = 2;
    localparam int unsigned E_WAVE_BIT = 1;
    localparam int unsigned E_MASK_BIT = 0;
    localparam int unsigned F_TEST_BIT = 3;
    localparam int unsigned F_24H_BIT = 2;
    localparam int unsigned F_STOP_BIT = 1;
    localparam int unsigned F_RESET_BIT = 0;
    localparam int unsigned HR10_PM_BIT = 2;

    // ----------------------------------------
    // values after reset
    // ----------------------------------------
    localparam logic [3:0] RST_DAY_ONES = 4'h1;
    localparam logic [3:0] RST_MONTH_ONES = 4'h1;
    localparam logic [3:0] RST_CTRL_IRQ_SETUP = 4'h0;
    localparam logic [3:0] RST_CTRL_COUNT_SETUP = 4'h4;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        PER_64TH = 2'h0,
        PER_SECOND = 2'h1,
        PER_MINUTE = 2'h2,
        PER_HOUR = 2'h3
    } bcc_period_t;

    typedef enum logic [2:0] {
        IRQ_IDLE = 3'h1,
        IRQ_PULSE = 3'h2,
        IRQ_LATCH = 3'h4
    } bcc_irq_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } bcc_bus_t;

    typedef struct packed {
        logic [3:0] seconds_ones;
        logic [2:0] seconds_tens;
        logic [3:0] minutes_ones;
        logic [2:0] minutes_tens;
        logic [3:0] hr1;
        logic [1:0] hr10;
        logic pm;
        logic [3:0] day1;
        logic [1:0] day10;
        logic [3:0] mon1;
        logic mon10;
        logic [3:0] yr1;
        logic [1:0] yr10;
        logic [2:0] dow;
    } bcc_time_t;

endpackage

`default_nettype wire

// ### design/bcc_timebase.sv
`timescale 1ns/100ps
`default_nettype none

module bcc_timebase #(
    parameter int unsigned PRESCALE = bcc_pkg::PRESCALE_CYCLES,
    parameter int unsigned CHAIN_W = bcc_pkg::CHAIN_BITS
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // control
    input wire logic stop_in,
    input wire logic clear_in,
    // tick enables
    output logic base_tick_out,
    output logic tick64_out,
    output logic sec_tick_out
);

    localparam int unsigned PW = $clog2(PRESCALE);
    localparam logic [PW-1:0] PRESC_LAST = PW'(PRESCALE - 1);
    localparam int unsigned T64 = bcc_pkg::TICK64_BITS;

    generate
        if (PRESCALE < 2 || CHAIN_W <= T64)
        begin : g_bad
            $error("bad prescale or chain width");
        end
    endgenerate

    typedef struct packed {
        logic [PW-1:0] presc;
        logic [CHAIN_W-1:0] chain;
        logic base;
        logic t64;
        logic sec;
    } bcc_tb_state_t;

    bcc_tb_state_t s;
    bcc_tb_state_t next_s;

    // prescaler, then binary divider chain
    always_comb
    begin
        next_s = s;
        next_s.base = 1'b0;
        next_s.t64 = 1'b0;
        next_s.sec = 1'b0;
        if (clear_in)
        begin
            next_s.presc = '0;
            next_s.chain = '0;
        end
        else if (!stop_in)
        begin
            if (s.presc == PRESC_LAST)
            begin
                next_s.presc = '0;
                next_s.base = 1'b1;
                next_s.chain = s.chain + 1'b1;
                next_s.t64 = &s.chain[T64-1:0];
                next_s.sec = &s.chain; // chain carry
            end
            else
            begin
                next_s.presc = s.presc + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            s <= '0;
        else
            s <= next_s;
    end

    assign base_tick_out = s.base;
    assign tick64_out = s.t64;
    assign sec_tick_out = s.sec;

endmodule

`default_nettype wire

// ### test/bcc_chk.sv
`timescale 1ns/100ps
`default_nettype none

module bcc_chk #(
    parameter int unsigned IRQ_PULSE_CYCLES = 4
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // host bus and outputs
    input wire bcc_pkg::bcc_bus_t bus_in,
    input wire logic [7:0] rdata_out,
    input wire logic irq_n_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    logic mask_q;
    logic wave_q;
    int unsigned low_cnt;

    // decoded host accesses
    wire logic rd_d = bus_in.rd && bus_in.addr == 4'hD;
    wire logic e_wr = bus_in.wr && bus_in.addr == 4'hE;
    wire logic clr_wr = bus_in.wr && bus_in.addr == 4'hD && !bus_in.wdata[2];

    // setup shadow and low-phase length
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            mask_q <= 1'b0;
            wave_q <= 1'b0;
            low_cnt <= 0;
        end
        else
        begin
            if (e_wr)
            begin
                mask_q <= bus_in.wdata[0];
                wave_q <= bus_in.wdata[1];
            end
            low_cnt <= irq_n_out ? 0 : low_cnt + 1;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    rd_hold_a: assert property (!bus_in.rd |=> $stable(rdata_out))
        else $error("rdata moved");
    ctrl_upper_a: assert property (bus_in.rd && bus_in.addr >= 4'hD
        |=> rdata_out[7:4] == 4'h0) else $error("ctrl upper bits");
    cmd_bits_a: assert property (rd_d
        |=> !rdata_out[3] && !rdata_out[0]) else $error("cmd bits set");
    sec_tens_a: assert property (bus_in.rd && bus_in.addr == 4'h1
        |=> rdata_out[7:3] == 5'h00) else $error("sec tens wide");
    digit_ones_a: assert property (bus_in.rd
        && bus_in.addr inside {4'h0, 4'h2, 4'h4, 4'hA}
        |=> rdata_out[7:4] == 4'h0) else $error("units wide");
    hour_tens_a: assert property (bus_in.rd && bus_in.addr == 4'h5
        |=> rdata_out[7:3] == 5'h00) else $error("hour tens wide");
    dow_code_a: assert property (bus_in.rd && bus_in.addr == 4'hC
        |=> rdata_out[7:3] == 5'h00 && rdata_out[2:0] != 3'h7)
        else $error("bad weekday");
    mask_out_a: assert property (mask_q && $past(mask_q) |-> irq_n_out)
        else $error("masked irq low");
    latch_hold_a: assert property (wave_q && !mask_q && !irq_n_out
        && !e_wr && !clr_wr |=> !irq_n_out) else $error("latch released");
    pulse_len_a: assert property ($rose(irq_n_out) && !wave_q
        && !mask_q && $stable(mask_q) |-> low_cnt == IRQ_PULSE_CYCLES)
        else $error("pulse length");
    flag_read_a: assert property (rd_d && !mask_q && $stable(mask_q)
        |=> rdata_out[2] == !$past(irq_n_out)) else $error("flag mismatch");

    // main scenarios
    fall_c: cover property ($fell(irq_n_out));
    round_c: cover property (bus_in.wr && bus_in.addr == 4'hD && bus_in.wdata[3]);
    clear_c: cover property (wave_q && $rose(irq_n_out));
endmodule

bind bcc_calendar_clock bcc_chk #(.IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES)) chk_u (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .bus_in(bus_in),
    .rdata_out(rdata_out),
    .irq_n_out(irq_n_out)
);

`default_nettype wire

// ### test/bcc_host_mdl.sv
`timescale 1ns/100ps
`default_nettype none

module bcc_host_mdl (
    // clock
    input wire logic clk_in,
    // location bus
    output var bcc_pkg::bcc_bus_t bus_out,
    input wire logic [7:0] rdata_in
);
    initial bus_out = '0;

    // one strobe cycle; idle lines then show the inverse
    task automatic raw(input logic w, input logic [3:0] a,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_in);
        bus_out.rd <= !w;
        bus_out.wr <= w;
        bus_out.addr <= a;
        bus_out.wdata <= d;
        @(posedge clk_in);
        bus_out.rd <= 1'b0;
        bus_out.wr <= 1'b0;
        bus_out.addr <= ~a;
        bus_out.wdata <= ~d;
        @(posedge clk_in);
        q = rdata_in;
    endtask

    // counters touched once busy reads 0, or after 16 busy polls
    task automatic xfer(input logic w, input logic [3:0] a,
        input logic [7:0] d, output logic [7:0] q);
        logic [7:0] st = 8'h02;
        int n = 0;
        while (a < 4'hD && st[1] !== 1'b0 && n < 16)
        begin
            raw(1'b0, 4'hD, 8'h00, st);
            n++;
        end
        raw(w, a, d, q);
    endtask
endmodule

`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    typedef logic [7:0] bcc_vec_t [13];
    localparam int unsigned PULSE = 4;
    localparam int unsigned PRE = 2;
    logic clk_in;
    logic reset_n_in;
    bcc_pkg::bcc_bus_t bus;
    logic [7:0] rdata;
    logic irq_n;
    logic [7:0] q;
    logic [7:0] junk;
    bcc_vec_t v;
    int n_errors;
    int check_count;
    int k;
    int n1;
    int n2;
    int lim [13] = '{10, 6, 10, 6, 10, 2, 9, 3, 9, 1, 10, 4, 7};
    logic [1:0] per_sel [3] = '{2'h0, 2'h2, 2'h3};

    bcc_calendar_clock #(.IRQ_PULSE_CYCLES(PULSE), .PRESCALE(PRE)) dut_u (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .bus_in(bus),
        .rdata_out(rdata),
        .irq_n_out(irq_n)
    );
    bcc_host_mdl h_u (.clk_in(clk_in), .bus_out(bus), .rdata_in(rdata));

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_n(input int got, input int exp);
        check_count++;
        if (got != exp)
        begin
            n_errors++;
            $display("[ERR] %0t count %0d exp %0d", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        h_u.xfer(1'b1, a, d, junk);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
        input logic [7:0] m = 8'hFF);
        h_u.xfer(1'b0, a, 8'h00, q);
        check8(q & m, e);
    endtask

    task automatic irq_chk(input logic e);
        repeat (2) @(posedge clk_in);
        check8(8'(irq_n), 8'(e));
    endtask

    task automatic load(input bcc_vec_t x);
        for (int i = 0; i < 13; i++)
            wr(4'(i), x[i]);
        wr(4'hD, 8'h01);
    endtask

    task automatic read_all(input bcc_vec_t e);
        for (int i = 0; i < 13; i++)
            rd_chk(4'(i), e[i]);
    endtask

    task automatic wait_lvl(input logic lvl, output int n);
        n = 0;
        while (irq_n !== lvl && n < 20000)
        begin
            @(posedge clk_in);
            n++;
        end
    endtask

    // calendar one second after 23:59:59 or 11:59:59 PM on 28 Feb
    function automatic bcc_vec_t roll_exp(input int c);
        bcc_vec_t e = '{default: 8'h00};
        e[4] = (c == 2) ? 8'h02 : 8'h00;
        e[5] = (c == 2) ? 8'h01 : 8'h00;
        e[6] = (c == 0) ? 8'h01 : 8'h09;
        e[7] = (c == 0) ? 8'h00 : 8'h02;
        e[8] = (c == 0) ? 8'h03 : 8'h02;
        e[10] = (c == 0) ? 8'h03 : 8'h04;
        return e;
    endfunction

    function automatic int period(input logic [1:0] p);
        return PRE * ((p == 2'h0) ? 512 : (p == 2'h2) ? 60 : 3600);
    endfunction

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ----------------------------------------
    // clock and watchdog
    // ----------------------------------------
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    initial
    begin
        repeat (60000) @(posedge clk_in);
        n_errors++;
        $display("[ERR] %0t timeout", $time);
        summarize();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        reset_n_in = 1'b0;
        n_errors = 0;
        check_count = 0;
        k = $urandom(8486);
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd_chk(4'hE, 8'h00);
        rd_chk(4'hF, 8'h04);
        rd_chk(4'h8, 8'h01);
        wr(4'hF, 8'h0E);
        // random load and read back
        repeat (2)
        begin
            for (int i = 0; i < 13; i++)
                v[i] = 8'($urandom % lim[i]);
            v[6] += 8'h01;
            v[8] += 8'h01;
            load(v);
            read_all(v);
        end
        // rounding either side of 29 s
        for (int c = 0; c < 2; c++)
        begin
            load('{(c == 0) ? 8'h09 : 8'h00, 8'(2 + c), 8'h02, 8'h01,
                8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00});
            wr(4'hD, 8'h08);
            rd_chk(4'h0, 8'h00);
            rd_chk(4'h1, 8'h00);
            rd_chk(4'h2, 8'(2 + c));
        end
        // one fast second from a cleared divider rolls the calendar
        for (int c = 0; c < 3; c++)
        begin
            wr(4'hF, (c == 2) ? 8'h0B : 8'h0F);
            load('{8'h09, 8'h05, 8'h09, 8'h05, (c == 2) ? 8'h01 : 8'h03,
                (c == 2) ? 8'h05 : 8'h02, 8'h08, 8'h02, 8'h02, 8'h00,
                (c == 0) ? 8'h03 : 8'h04, 8'h00, 8'h06});
            q = 8'h09;
            k = 0;
            while (q === 8'h09 && k < 8)
            begin
                wr(4'hF, (c == 2) ? 8'h08 : 8'h0C);
                wr(4'hF, (c == 2) ? 8'h0A : 8'h0E);
                h_u.xfer(1'b0, 4'h0, 8'h00, q);
                k++;
            end
            read_all(roll_exp(c));
        end
        // pulse width and period
        wr(4'hF, 8'h0C);
        foreach (per_sel[i])
        begin
            wr(4'hE, {4'h0, per_sel[i], 2'b00});
            for (int j = 0; j < 5; j++)
                wait_lvl(!j[0], n1);
            wait_lvl(1'b0, n2);
            check_n(n1, PULSE);
            check_n(n1 + n2, period(per_sel[i]));
        end
        // latched mode, masking, flag and clear
        wait_lvl(1'b1, n1);
        wr(4'hE, 8'h06);
        wait_lvl(1'b0, n1);
        check_n(int'(n1 < 8), 1);
        repeat (8) @(posedge clk_in);
        irq_chk(1'b0);
        rd_chk(4'hD, 8'h04, 8'hFD);
        wr(4'hE, 8'h07);
        irq_chk(1'b1);
        rd_chk(4'hD, 8'h04, 8'hFD);
        wr(4'hF, 8'h0E);
        wr(4'hE, 8'h06);
        irq_chk(1'b0);
        wr(4'hD, 8'h04);
        irq_chk(1'b0);
        wr(4'hD, 8'h00);
        irq_chk(1'b1);
        summarize();
    end
endmodule

`default_nettype wire
